// ==== bench/as_link_sva.sv ====
// Concurrent checks on the four-wire link between master and sensor.
`timescale 1ns/1ps
module as_link_sva
  import as_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Link wires
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe_n,
  input wire logic miso_line
);
  //**************************************************************
  // Helper logic
  //**************************************************************
  logic       sclk_q;  // Serial clock one cycle ago
  logic       cs_q;    // Select one cycle ago
  logic [4:0] rise_q;  // Rising clock edges seen in frame

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  // Delayed copies for edge finding
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sclk_q <= 1'b0;
      cs_q   <= 1'b1;
    end else begin
      sclk_q <= sclk;
      cs_q   <= cs_n;
    end
  end

  // Rising edges inside a frame, ignoring an edge made with select
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rise_q <= 5'h00;
    end else if (cs_n) begin
      rise_q <= 5'h00;
    end else if (!cs_q && sclk && !sclk_q) begin
      rise_q <= rise_q + 5'h01;
    end
  end

  //**************************************************************
  // Assertions
  //**************************************************************
  chk_oe_follows_select: assert property (miso_oe_n == cs_n)
    else $error("MISO enable does not follow chip select");
  chk_line_pulled_low: assert property (miso_oe_n |-> miso_line == 1'b0)
    else $error("Released MISO line not low");
  chk_miso_still_high: assert property (!cs_n && sclk && sclk_q && rise_q != 5'h00 |-> $stable(miso))
    else $error("MISO changed while serial clock high");
  chk_mosi_still_high: assert property (!cs_n && sclk && sclk_q && rise_q != 5'h00 |-> $stable(mosi))
    else $error("MOSI changed while serial clock high");
  chk_frame_clock_count: assert property ($rose(cs_n) |-> rise_q == AS_BITS_PLAIN || rise_q == AS_BITS_PAR)
    else $error("Frame ended with wrong clock count");
  chk_clock_count_max: assert property (rise_q <= AS_BITS_PAR)
    else $error("More than seventeen clocks in a frame");
  chk_select_setup: assert property ($fell(cs_n) |-> ##1 $stable(sclk) [*3])
    else $error("Serial clock moved too soon after select fall");
  chk_idle_gap: assert property ($rose(cs_n) |-> cs_n [*8])
    else $error("Select idle gap too short");
  chk_sclk_half_min: assert property (!cs_n && $changed(sclk) |=> $stable(sclk))
    else $error("Serial clock half period too short");

  // Main scenarios
  cov_mode0_start: cover property ($fell(cs_n) && !sclk);
  cov_mode3_start: cover property ($fell(cs_n) && sclk);
  cov_parity_frame: cover property ($rose(cs_n) && rise_q == AS_BITS_PAR);
  cov_plain_frame: cover property ($rose(cs_n) && rise_q == AS_BITS_PLAIN);
endmodule : as_link_sva

// ==== bench/test_angle_sensor_spi_slave.sv ====
// Self-checking bench joining the master and sensor ends over the link.
`timescale 1ns/1ps
module test_angle_sensor_spi_slave;
  import as_pkg::*;
  //**************************************************************
  // Signals
  //**************************************************************
  logic        clk_i;         // System clock
  logic        resetn_i;      // Reset, low active
  logic [15:0] angle_raw;     // Front-end sample
  logic [15:0] angle_o;       // Sensor output buffer
  logic        req;           // Master request
  as_op_t      op;            // Operation kind
  logic [4:0]  addr;          // Register address
  logic [7:0]  wdata;         // Register write value
  logic        mode3;         // Link mode select
  logic        parity;        // Seventeenth clock wanted
  logic        busy;          // Master busy
  logic        done;          // Master answer pulse
  logic [15:0] rdata;         // Master answer word
  logic        par_ok;        // Parity verdict
  logic [16:0] exp_q[$];      // Expected parity verdict and word
  logic [16:0] exp_w;         // Oldest note
  logic [7:0]  zero_b;        // Offset byte written
  int          errors;        // Mismatches
  int          total_checks;  // Comparisons
  int          seed;          // Random seed

  as_spi_if u_as_spi_if ();
  as_dev u_as_dev (.clk_i(clk_i), .resetn_i(resetn_i), .angle_raw_i(angle_raw), .angle_o(angle_o),
                   .spi(u_as_spi_if.dev));
  as_mst #(.NVM_CYC(50)) u_as_mst (.clk_i(clk_i), .resetn_i(resetn_i), .req_i(req), .op_i(op), .addr_i(addr),
                   .wdata_i(wdata), .mode3_i(mode3), .parity_i(parity), .busy_o(busy), .done_o(done),
                   .rdata_o(rdata), .par_ok_o(par_ok), .spi(u_as_spi_if.mst));
  as_link_sva u_as_link_sva (.clk_i(clk_i), .resetn_i(resetn_i), .cs_n(u_as_spi_if.cs_n),
                   .sclk(u_as_spi_if.sclk), .mosi(u_as_spi_if.mosi), .miso(u_as_spi_if.miso),
                   .miso_oe_n(u_as_spi_if.miso_oe_n), .miso_line(u_as_spi_if.miso_line));

  // Free-running system clock
  initial clk_i = 1'b0;
  always #10 clk_i = ~clk_i;

  //**************************************************************
  // Tasks
  //**************************************************************
  // Compare and count
  task automatic check(input string name, input logic [16:0] seen, input logic [16:0] expv);
    total_checks++;
    if (seen !== expv) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, expv, seen);
    end
  endtask : check

  // Verdict and end of run
  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Bounded wait for the master to go idle
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 2000) begin
      errors++;
      report_and_stop();
    end
  endtask : wait_idle

  // Issue one request, note its answer, hold until taken
  task automatic start_op(input as_op_t o, input logic [4:0] a, input logic [7:0] d, input logic m3,
                          input logic p, input logic [16:0] e);
    int n;
    wait_idle();
    op    = o;
    addr  = a;
    wdata = d;
    mode3 = m3;
    parity = p;
    req   = 1'b1;
    exp_q.push_back(e);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (busy !== 1'b1 && n < 60);
    req = 1'b0;
    if (n >= 60) begin
      errors++;
      report_and_stop();
    end
  endtask : start_op

  // Expected angle from raw sample, offset byte and direction
  function automatic logic [15:0] exp_angle(input logic [15:0] raw, input logic [7:0] z, input logic dr);
    logic [15:0] a;
    a = raw - {z, 8'h00};
    if (dr) begin
      a = 16'h0000 - a;
    end
    return a & AS_ANGLE_MASK;
  endfunction : exp_angle

  // Answer watcher takes the oldest note on each done pulse
  always @(negedge clk_i) begin
    if (done === 1'b1) begin
      if (exp_q.size() == 0) begin
        errors++;
        $display("ERROR answer expected none seen %h", rdata);
      end else begin
        exp_w = exp_q.pop_front();
        check("answer", {par_ok, rdata}, exp_w);
      end
    end
  end

  //**************************************************************
  // Main sequence
  //**************************************************************
  initial begin
    seed = 97754;
    errors = 0;
    total_checks = 0;
    resetn_i = 1'b0;
    req = 1'b0;
    op = AS_OP_ANGLE;
    addr = 5'h00;
    wdata = 8'h00;
    mode3 = 1'b0;
    parity = 1'b0;
    angle_raw = 16'h0000;
    zero_b = 8'($random(seed));
    repeat (3) @(negedge clk_i);
    resetn_i = 1'b1;
    check("answer after reset", {par_ok, rdata}, 17'h00000);
    // Register reset values
    start_op(AS_OP_RD, AS_REG_ZERO, 8'h00, 1'b0, 1'b1, {1'b1, AS_CFG_RESET, 8'h00});
    start_op(AS_OP_RD, AS_REG_DIR, 8'h00, 1'b1, 1'b0, {1'b1, AS_CFG_RESET, 8'h00});
    // Buffer refresh
    wait_idle();
    angle_raw = 16'($random(seed));
    repeat (60) @(negedge clk_i);
    check("angle buffer", {1'b0, angle_o}, {1'b0, angle_raw & AS_ANGLE_MASK});
    // Every mode and parity choice
    for (int i = 0; i < 4; i++) begin
      wait_idle();
      angle_raw = 16'($random(seed));
      repeat (60) @(negedge clk_i);
      start_op(AS_OP_ANGLE, 5'h00, 8'h00, i[0], i[1], {1'b1, angle_raw & AS_ANGLE_MASK});
    end
    // Freeze during frame, then release
    wait_idle();
    repeat (60) @(negedge clk_i);
    start_op(AS_OP_ANGLE, 5'h00, 8'h00, 1'b1, 1'b1, {1'b1, angle_raw & AS_ANGLE_MASK});
    repeat (10) @(negedge clk_i);
    angle_raw = ~angle_raw;
    repeat (55) @(negedge clk_i);
    check("frozen buffer", {1'b0, angle_o}, {1'b0, ~angle_raw & AS_ANGLE_MASK});
    wait_idle();
    repeat (60) @(negedge clk_i);
    start_op(AS_OP_ANGLE, 5'h00, 8'h00, 1'b0, 1'b1, {1'b1, angle_raw & AS_ANGLE_MASK});
    start_op(AS_OP_ANGLE, 5'h00, 8'h00, 1'b1, 1'b0, {1'b1, angle_raw & AS_ANGLE_MASK});
    // Write and read back in both modes
    for (int m = 0; m < 2; m++) begin
      start_op(AS_OP_WR, AS_REG_ZERO, zero_b, m[0], 1'b1, {1'b1, zero_b, 8'h00});
      start_op(AS_OP_RD, AS_REG_ZERO, 8'h00, m[0], 1'b1, {1'b1, zero_b, 8'h00});
    end
    // Offset applied
    wait_idle();
    angle_raw = {12'($random(seed)), 4'h0};
    repeat (60) @(negedge clk_i);
    start_op(AS_OP_ANGLE, 5'h00, 8'h00, 1'b0, 1'b1, {1'b1, exp_angle(angle_raw, zero_b, 1'b0)});
    // Reversed direction
    start_op(AS_OP_WR, AS_REG_DIR, 8'h80, 1'b1, 1'b0, {1'b1, 8'h80, 8'h00});
    start_op(AS_OP_RD, AS_REG_DIR, 8'h00, 1'b0, 1'b0, {1'b1, 8'h80, 8'h00});
    wait_idle();
    repeat (60) @(negedge clk_i);
    start_op(AS_OP_ANGLE, 5'h00, 8'h00, 1'b1, 1'b1, {1'b1, exp_angle(angle_raw, zero_b, 1'b1)});
    wait_idle();
    repeat (5) @(negedge clk_i);
    if (exp_q.size() != 0) begin
      errors++;
      $display("ERROR answers missing expected 0 seen %0d", exp_q.size());
    end
    report_and_stop();
  end
endmodule : test_angle_sensor_spi_slave

// ==== design/as_dev.sv ====
// Sensor end: angle buffer, register file and SPI slave.
`timescale 1ns/1ps
module as_dev (
  // System clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // Front-end angle sample
  input  wire logic [15:0] angle_raw_i,
  output logic      [15:0] angle_o,
  // SPI link
  as_spi_if.dev            spi
);
  import as_pkg::*;

  //**************************************************************
  // Declarations
  //**************************************************************
  logic        cs_s1_q, cs_s2_q;      // Select synchroniser
  logic        dir_s1_q, dir_s2_q;    // Direction synchroniser
  logic [7:0]  zero_s1_q, zero_s2_q;  // Zero offset synchroniser
  logic [5:0]  ref_cnt_q;             // Refresh divider
  logic [15:0] angle_q;               // Output buffer
  logic [15:0] rx_q;                  // Incoming shift register
  logic [4:0]  rcnt_q;                // Rising edges in frame
  logic        rose_q;                // A rising edge was seen
  logic [15:0] word_q;                // Word held after first rise
  logic [7:0]  cfg_q [0:31];          // Configuration registers
  logic        pend_q;                // Register reply owed
  logic [7:0]  reply_q;               // Register reply byte
  logic [4:0]  fcnt_q;                // Falling edges in frame
  logic        m3_q;                  // Mode 3 detected
  logic        fell_q;                // A falling edge was seen
  logic        miso_q;                // Shifted output bit
  logic [15:0] live_word;             // Word to send this frame
  logic [15:0] tx_word;               // Stable word for the frame
  logic [15:0] frame;                 // Complete received frame
  logic        m3_now;                // Mode at this falling edge
  logic [4:0]  pos;                   // Next output position

  // Angle relative to zero, in chosen direction, padded low
  function automatic logic [15:0] as_angle_f(input logic [15:0] raw,
                                             input logic [7:0]  zero,
                                             input logic        dir);
    logic [15:0] rel;
    rel = dir ? ({zero, AS_ZERO_BYTE} - raw) : (raw - {zero, AS_ZERO_BYTE});
    return rel & AS_ANGLE_MASK;
  endfunction : as_angle_f

  //**************************************************************
  // System clock side
  //**************************************************************

  // Select and configuration levels into clk_i domain
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cs_s1_q   <= 1'b1;
      cs_s2_q   <= 1'b1;
      dir_s1_q  <= 1'b0;
      dir_s2_q  <= 1'b0;
      zero_s1_q <= AS_CFG_RESET;
      zero_s2_q <= AS_CFG_RESET;
    end else begin
      cs_s1_q   <= spi.cs_n;
      cs_s2_q   <= cs_s1_q;
      dir_s1_q  <= cfg_q[AS_REG_DIR][AS_DIR_BIT];
      dir_s2_q  <= dir_s1_q;
      zero_s1_q <= cfg_q[AS_REG_ZERO];
      zero_s2_q <= zero_s1_q;
    end
  end

  // One-microsecond refresh divider
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ref_cnt_q <= 6'h00;
    end else if (ref_cnt_q == AS_REFRESH_CYC - 6'h01) begin
      ref_cnt_q <= 6'h00;
    end else begin
      ref_cnt_q <= ref_cnt_q + 6'h01;
    end
  end

  // Output buffer, refreshed only while deselected
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      angle_q <= 16'h0000;
    end else if (ref_cnt_q == AS_REFRESH_CYC - 6'h01 && cs_s2_q) begin
      angle_q <= as_angle_f(angle_raw_i, zero_s2_q, dir_s2_q);
    end
  end

  assign angle_o = angle_q;

  //**************************************************************
  // Link side, rising edges
  //**************************************************************

  // Frame as it stands after this rising edge
  assign frame = {rx_q[14:0], spi.mosi};

  // Receive shift and edge count, cleared by select high
  always_ff @(posedge spi.sclk or posedge spi.cs_n) begin
    if (spi.cs_n) begin
      rx_q   <= 16'h0000;
      rcnt_q <= 5'h00;
      rose_q <= 1'b0;
      word_q <= 16'h0000;
    end else begin
      rx_q   <= frame;
      rose_q <= 1'b1;
      if (rcnt_q != AS_BITS_PAR) begin
        rcnt_q <= rcnt_q + 5'h01;
      end
      if (!rose_q) begin
        word_q <= live_word; // Hold word across the end of frame
      end
    end
  end

  // Decode of a complete command frame
  always_ff @(posedge spi.sclk or negedge resetn_i) begin
    if (!resetn_i) begin
      pend_q  <= 1'b0;
      reply_q <= AS_CFG_RESET;
      for (int i = 0; i < 32; i++) begin
        cfg_q[i] <= AS_CFG_RESET;
      end
    end else if (!spi.cs_n && rcnt_q == AS_LAST_BIT) begin
      if (frame[15:13] == AS_CMD_WR) begin
        cfg_q[frame[12:8]] <= frame[7:0];
        reply_q            <= frame[7:0];
        pend_q             <= 1'b1;
      end else if (frame[15:13] == AS_CMD_RD) begin
        reply_q <= cfg_q[frame[12:8]];
        pend_q  <= 1'b1;
      end else begin
        pend_q  <= 1'b0; // Angle readout
      end
    end
  end

  //**************************************************************
  // Link side, falling edges
  //**************************************************************

  // Register reply takes the place of the angle
  assign live_word = pend_q ? {reply_q, AS_ZERO_BYTE} : angle_q;
  assign tx_word   = rose_q ? word_q : live_word;

  // Mode 3 when a fall comes before any rise
  assign m3_now = (fcnt_q == 5'h00) ? !rose_q : m3_q;
  assign pos    = fcnt_q + {4'h0, !m3_now};

  // Output shift on falling edges
  always_ff @(negedge spi.sclk or posedge spi.cs_n) begin
    if (spi.cs_n) begin
      fcnt_q <= 5'h00;
      m3_q   <= 1'b0;
      fell_q <= 1'b0;
      miso_q <= 1'b0;
    end else begin
      fell_q <= 1'b1;
      m3_q   <= m3_now;
      if (fcnt_q != AS_BITS_PAR) begin
        fcnt_q <= fcnt_q + 5'h01;
      end
      if (pos < AS_PAR_POS) begin
        miso_q <= tx_word[4'(AS_LAST_BIT - pos)];
      end else if (pos == AS_PAR_POS) begin
        miso_q <= as_par_f(tx_word);
      end else begin
        miso_q <= 1'b0;
      end
    end
  end

  // First bit shows as soon as the frame opens
  assign spi.miso      = fell_q ? miso_q : tx_word[15];
  assign spi.miso_oe_n = spi.cs_n;

endmodule : as_dev

// ==== design/as_mst.sv ====
// Master end: SPI controller making the link clock.
`timescale 1ns/1ps
module as_mst #(
  parameter int NVM_CYC = as_pkg::AS_NVM_CYC  // Settle after write
) (
  // System clock and reset
  input  wire logic          clk_i,
  input  wire logic          resetn_i,
  // Request
  input  wire logic          req_i,
  input  wire as_pkg::as_op_t op_i,
  input  wire logic [4:0]    addr_i,
  input  wire logic [7:0]    wdata_i,
  input  wire logic          mode3_i,
  input  wire logic          parity_i,
  // Answer
  output logic               busy_o,
  output logic               done_o,
  output logic [15:0]        rdata_o,
  output logic               par_ok_o,
  // SPI link
  as_spi_if.mst              spi
);
  import as_pkg::*;

  //**************************************************************
  // Declarations
  //**************************************************************
  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_LOW, ST_HIGH, ST_HOLD, ST_GAP} as_st_t;

  as_st_t      state_q;            // Frame sequencer
  logic [19:0] cnt_q;              // Phase and gap timer
  logic [4:0]  bit_q;              // Bit within frame
  logic [4:0]  nbits_q;            // Clocks per frame
  logic [15:0] tx_q;               // Outgoing shift register
  logic [15:0] cmd_q;              // Command frame
  logic [16:0] rx_q;               // Incoming shift register
  logic        second_q;           // Reply frame still to run
  as_op_t      op_q;               // Operation in progress
  logic        m3_q;               // Clock idles high
  logic        cs_n_q, sclk_q, mosi_q;
  logic        miso_s1_q, miso_s2_q; // MISO synchroniser
  logic        busy_q, done_q, par_ok_q;
  logic [15:0] rdata_q;
  logic [19:0] idle_q;             // Cycles with select high, saturating
  logic        start_ok;           // A request may open a frame now

  //**************************************************************
  // MISO into clk_i domain
  //**************************************************************
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      miso_s1_q <= 1'b0;
      miso_s2_q <= 1'b0;
    end else begin
      miso_s1_q <= spi.miso_line;
      miso_s2_q <= miso_s1_q;
    end
  end

  //**************************************************************
  // Idle time before a register sequence
  //**************************************************************
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      idle_q <= AS_IDLE_REG_CYC;
    end else if (!cs_n_q) begin
      idle_q <= 20'h00000;
    end else if (idle_q != AS_IDLE_REG_CYC) begin
      idle_q <= idle_q + 20'h00001;
    end
  end

  // Clock already parked; register sequences also need the long idle
  assign start_ok = req_i && (sclk_q == mode3_i) &&
                    (op_i == AS_OP_ANGLE || idle_q == AS_IDLE_REG_CYC);

  //**************************************************************
  // Frame sequencer
  //**************************************************************
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q  <= ST_IDLE;
      cnt_q    <= 20'h00000;
      bit_q    <= 5'h00;
      nbits_q  <= AS_BITS_PLAIN;
      tx_q     <= 16'h0000;
      cmd_q    <= 16'h0000;
      rx_q     <= 17'h00000;
      second_q <= 1'b0;
      op_q     <= AS_OP_ANGLE;
      m3_q     <= 1'b0;
      cs_n_q   <= 1'b1;
      sclk_q   <= 1'b0;
      mosi_q   <= 1'b0;
      busy_q   <= 1'b0;
      done_q   <= 1'b0;
      par_ok_q <= 1'b0;
      rdata_q  <= 16'h0000;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          sclk_q <= mode3_i;      // Park at the mode's idle level before select falls
          if (start_ok) begin
            busy_q   <= 1'b1;
            op_q     <= op_i;
            m3_q     <= mode3_i;
            nbits_q  <= parity_i ? AS_BITS_PAR : AS_BITS_PLAIN;
            second_q <= (op_i != AS_OP_ANGLE);
            if (op_i == AS_OP_WR) begin
              tx_q <= {AS_CMD_WR, addr_i, wdata_i};
            end else if (op_i == AS_OP_RD) begin
              tx_q <= {AS_CMD_RD, addr_i, AS_ZERO_BYTE};
            end else begin
              tx_q <= 16'h0000;
            end
            cs_n_q  <= 1'b0;
            cnt_q   <= AS_SETUP_CYC - 20'h00001;
            state_q <= ST_SETUP;
          end
        end
        ST_SETUP, ST_HIGH: begin
          if (cnt_q != 20'h00000) begin
            cnt_q <= cnt_q - 20'h00001;
          end else if (state_q == ST_HIGH && bit_q == nbits_q - 5'h01) begin
            rx_q    <= {rx_q[15:0], miso_s2_q};
            cnt_q   <= AS_HOLD_CYC - 20'h00001;
            state_q <= ST_HOLD;
          end else begin
            if (state_q == ST_HIGH) begin
              rx_q  <= {rx_q[15:0], miso_s2_q};
              bit_q <= bit_q + 5'h01;
            end
            sclk_q  <= 1'b0;         // Falling edge, new MOSI bit
            mosi_q  <= tx_q[15];
            tx_q    <= {tx_q[14:0], 1'b0};
            cnt_q   <= AS_HALF_CYC - 20'h00001;
            state_q <= ST_LOW;
          end
        end
        ST_LOW: begin
          if (cnt_q != 20'h00000) begin
            cnt_q <= cnt_q - 20'h00001;
          end else begin
            sclk_q  <= 1'b1;         // Rising edge, both sides sample
            cnt_q   <= AS_HALF_CYC - 20'h00001;
            state_q <= ST_HIGH;
          end
        end
        ST_HOLD: begin
          if (cnt_q != 20'h00000) begin
            cnt_q <= cnt_q - 20'h00001;
          end else begin
            cs_n_q  <= 1'b1;
            mosi_q  <= 1'b0;
            bit_q   <= 5'h00;
            state_q <= ST_GAP;
            if (second_q) begin
              cnt_q <= (op_q == AS_OP_WR) ? 20'(NVM_CYC) : AS_IDLE_REG_CYC;
            end else begin
              cnt_q    <= (op_q == AS_OP_ANGLE) ? AS_IDLE_ANGLE_CYC : AS_IDLE_REG_CYC;
              done_q   <= 1'b1;
              rdata_q  <= (nbits_q == AS_BITS_PAR) ? rx_q[16:1] : rx_q[15:0];
              par_ok_q <= (nbits_q == AS_BITS_PAR) ? !(^rx_q) : 1'b1;
            end
          end
        end
        ST_GAP: begin
          sclk_q <= m3_q;            // Clock returns to the mode's idle level while select is high
          if (cnt_q != 20'h00000) begin
            cnt_q <= cnt_q - 20'h00001;
          end else if (second_q) begin
            second_q <= 1'b0;        // Reply frame, MOSI all zero
            tx_q     <= 16'h0000;
            cs_n_q   <= 1'b0;
            cnt_q    <= AS_SETUP_CYC - 20'h00001;
            state_q  <= ST_SETUP;
          end else begin
            busy_q  <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Outputs straight from flops
  assign spi.cs_n = cs_n_q;
  assign spi.sclk = sclk_q;
  assign spi.mosi = mosi_q;
  assign busy_o   = busy_q;
  assign done_o   = done_q;
  assign rdata_o  = rdata_q;
  assign par_ok_o = par_ok_q;

endmodule : as_mst

// ==== design/as_pkg.sv ====
// Shared constants and types for the angle sensor SPI link.
//**************************************************************
// What this block does
// - Fresh angle loaded into output buffer every microsecond.
// - Angle direction and zero offset are programmable.
// - SPI carries angle reads and register access.
// - Sixteen-bit words; seventeenth clock returns parity bit.
// - Modes 0 and 3 accepted without configuration.
// - Master keeps serial clock at most 25 MHz.
// - Master sends every command as full 16-bit frame.
// - Sample MOSI on rising, change MISO on falling.
// - Chip select idles high; frames MSB first.
// - Master idles 150 ns between angle transfers.
// - Master idles 750 ns around register readouts.
// - Master waits 20 ms after register write.
// - Three operations: angle, register read, register write.
// - Buffer frozen while chip select is low.
// - Read: command 010, address, zeros; value follows.
// - Write: command 100, address, value; echo follows.
// - Angle bits below resolution are sent as zeros.
//**************************************************************
package as_pkg;

  //**************************************************************
  // Frame layout
  //**************************************************************
  localparam logic [4:0]  AS_LAST_BIT   = 5'h0F;   // Rising edge of bit 15
  localparam logic [4:0]  AS_PAR_POS    = 5'h10;   // Position of parity bit
  localparam logic [4:0]  AS_BITS_PLAIN = 5'h10;   // Sixteen clocks
  localparam logic [4:0]  AS_BITS_PAR   = 5'h11;   // Seventeen clocks
  localparam logic [2:0]  AS_CMD_RD     = 3'h2;    // Register read command
  localparam logic [2:0]  AS_CMD_WR     = 3'h4;    // Register write command
  localparam logic [7:0]  AS_ZERO_BYTE  = 8'h00;   // Low byte of reg replies
  localparam logic [15:0] AS_ANGLE_MASK = 16'hFFF0; // 12 useful angle bits

  //**************************************************************
  // Configuration registers
  //**************************************************************
  localparam logic [4:0]  AS_REG_ZERO   = 5'h00;   // Zero offset, high byte
  localparam logic [4:0]  AS_REG_DIR    = 5'h09;   // Direction register
  localparam int          AS_DIR_BIT    = 7;       // Direction bit position
  localparam logic [7:0]  AS_CFG_RESET  = 8'h00;   // Value after reset

  //**************************************************************
  // Timing
  //**************************************************************
  localparam int AS_CLK_NS        = 20;    // System clock period
  localparam int AS_REFRESH_NS    = 1000;  // Angle refresh period
  localparam int AS_IDLE_ANGLE_NS = 150;   // Gap after angle frame
  localparam int AS_IDLE_REG_NS   = 750;   // Gap around register frames
  localparam int AS_CS_SETUP_NS   = 80;    // Select low to first clock
  localparam int AS_CS_HOLD_NS    = 25;    // Last clock to select high
  localparam int AS_NVM_MS        = 20;    // Register write settle
  localparam logic [5:0]  AS_REFRESH_CYC = 6'(AS_REFRESH_NS / AS_CLK_NS);
  localparam logic [19:0] AS_IDLE_ANGLE_CYC =
    20'((AS_IDLE_ANGLE_NS + AS_CLK_NS - 1) / AS_CLK_NS);
  localparam logic [19:0] AS_IDLE_REG_CYC =
    20'((AS_IDLE_REG_NS + AS_CLK_NS - 1) / AS_CLK_NS);
  localparam logic [19:0] AS_SETUP_CYC =
    20'((AS_CS_SETUP_NS + AS_CLK_NS - 1) / AS_CLK_NS);
  localparam logic [19:0] AS_HOLD_CYC =
    20'((AS_CS_HOLD_NS + AS_CLK_NS - 1) / AS_CLK_NS);
  localparam int AS_NVM_CYC = AS_NVM_MS * 1000000 / AS_CLK_NS;
  localparam logic [19:0] AS_HALF_CYC = 20'h00002; // Serial clock half period

  //**************************************************************
  // Operations
  //**************************************************************
  typedef enum logic [1:0] {AS_OP_ANGLE, AS_OP_RD, AS_OP_WR} as_op_t;

  // Even parity bit over a word
  function automatic logic as_par_f(input logic [15:0] w);
    return ^w;
  endfunction : as_par_f

endpackage : as_pkg

// ==== design/as_spi_if.sv ====
// Four-wire SPI link between master and angle sensor.
`timescale 1ns/1ps
interface as_spi_if;
  logic cs_n;       // Chip select, low active
  logic sclk;       // Serial clock from master
  logic mosi;       // Master to sensor data
  logic miso;       // Sensor data value
  logic miso_oe_n;  // Sensor drives MISO when low
  logic miso_line;  // Resolved wire level

  // Pull-down keeps the line low when undriven
  assign miso_line = miso_oe_n ? 1'b0 : miso;

  modport dev (input cs_n, input sclk, input mosi, output miso, output miso_oe_n);
  modport mst (output cs_n, output sclk, output mosi, input miso_line);
endinterface : as_spi_if
